/* File: rtl/smart_attribute_command_unit.sv */
// Health-monitoring command unit: attribute sectors and autosave control
`timescale 1ns/1ps
`default_nettype none
module smart_attribute_command_unit #(
    parameter logic [28:0] YIELD_CYCLES = 29'(smart_pkg::YIELD_CYCLES)
) (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // Taskfile command
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic [7:0]  i_feature,
    input  wire logic [7:0]  i_count,
    input  wire logic [7:0]  i_cyl_lo,
    input  wire logic [7:0]  i_cyl_hi,
    input  wire logic [7:0]  i_command,
    // Completion
    output logic             o_done,
    output logic [7:0]       o_status,
    output logic [7:0]       o_error,
    output logic [7:0]       o_drive_head,
    // PIO data-in words
    output logic             o_data_valid,
    input  wire logic        i_data_ready,
    output logic [15:0]      o_data,
    // Attribute sources
    input  wire logic        i_uncorr_evt,
    input  wire logic        i_phy_err_evt,
    input  wire logic [15:0] i_power_on_hours,
    input  wire logic [31:0] i_power_cycles,
    input  wire logic [15:0] i_early_bad,
    input  wire logic [15:0] i_later_bad,
    input  wire logic [63:0] i_plane_bad,
    input  wire logic [15:0] i_bad_allowed,
    input  wire logic [15:0] i_max_erase,
    input  wire logic [15:0] i_avg_erase,
    input  wire logic        i_slc_mode,
    input  wire logic [31:0] i_power_loss,
    input  wire logic [7:0]  i_temp_cur,
    input  wire logic [7:0]  i_temp_low,
    input  wire logic [7:0]  i_temp_high,
    input  wire logic [31:0] i_crc_errs,
    input  wire logic [31:0] i_host_write_gb,
    // Persistent autosave state
    input  wire logic        i_nv_autosave,
    output logic             o_nv_wr,
    output logic             o_nv_autosave,
    output logic             o_autosave_en,
    // Attribute save control
    input  wire logic        i_save_event,
    input  wire logic        i_sys_save_event,
    input  wire logic        i_save_busy,
    output logic             o_save_req,
    output logic             o_save_yield
);
    typedef enum logic [1:0] {ST_IDLE, ST_YIELD, ST_BUILD, ST_DONE} state_t;

    // --------
    // Decode helpers
    // --------
    function automatic logic sig_ok(input logic [7:0] lo, input logic [7:0] hi,
                                    input logic [7:0] cmd);
        sig_ok = (lo == smart_pkg::SIG_CYL_LO) && (hi == smart_pkg::SIG_CYL_HI) &&
                 (cmd == smart_pkg::CMD_SMART);
    endfunction

    function automatic logic feat_known(input logic [7:0] feat, input logic [7:0] cnt);
        feat_known = (feat == smart_pkg::FEAT_READ_DATA) ||
                     (feat == smart_pkg::FEAT_READ_THR) ||
                     ((feat == smart_pkg::FEAT_AUTOSAVE) &&
                      ((cnt == smart_pkg::CNT_AS_OFF) || (cnt == smart_pkg::CNT_AS_ON)));
    endfunction

    state_t           state_r;
    logic [7:0]       feat_r;
    logic [7:0]       cnt_r;
    logic             abort_r;
    logic [28:0]      yield_cnt_r;
    logic [8:0]       pos_r;
    logic [3:0]       rec_r;
    logic [3:0]       off_r;
    logic [7:0]       sum_r;
    logic [7:0]       lo_byte_r;
    logic             autosave_r;
    logic             loaded_r;
    logic [7:0]       unc_cnt_r;
    logic [31:0]      phy_cnt_r;
    logic [7:0]       bad_val_r;
    logic [7:0]       life_r;
    logic [15:0]      plane_max;
    logic [31:0]      bad_q;
    logic [31:0]      life_q;
    logic [15:0]      erase_max;
    logic [47:0]      raw;
    logic [7:0]       val;
    logic [7:0]       worst;
    logic [7:0]       byte_now;
    logic             in_rec;
    logic             fifo_valid;
    logic             fifo_ready;
    logic             advance;
    logic             dispatch;
    logic             accept;

    assign accept      = i_cmd_valid && o_cmd_ready;
    assign o_cmd_ready = (state_r == ST_IDLE);
    assign o_autosave_en = autosave_r;
    assign o_save_yield  = (state_r == ST_YIELD);
    assign o_nv_autosave = autosave_r;

    // --------
    // Attribute arithmetic
    // --------

    // Largest bad-block count among planes
    always_comb begin
        plane_max = '0;
        for (int p = 0; p < smart_pkg::NPLANE; p++) begin
            if (i_plane_bad[p*16 +: 16] > plane_max) begin
                plane_max = i_plane_bad[p*16 +: 16];
            end
        end
    end

    // Bad-block and life-remaining percentages
    always_comb begin
        erase_max = i_slc_mode ? smart_pkg::ERASE_MAX_SLC : smart_pkg::ERASE_MAX_MLC;
        life_q    = ({16'h0, i_avg_erase} * smart_pkg::PCT_SCALE) / {16'h0, erase_max};
        if (i_bad_allowed == 16'h0 || plane_max >= i_bad_allowed) begin
            bad_q = 32'h0;
        end else begin
            bad_q = ({16'h0, 16'(i_bad_allowed - plane_max)} * smart_pkg::PCT_SCALE) /
                    {16'h0, i_bad_allowed};
        end
    end

    // Registered percentages, clamped
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bad_val_r <= smart_pkg::BAD_MIN;
            life_r    <= smart_pkg::VAL_FULL;
        end else begin
            if (bad_q < 32'(smart_pkg::BAD_MIN)) begin
                bad_val_r <= smart_pkg::BAD_MIN;
            end else if (bad_q > 32'(smart_pkg::VAL_FULL)) begin
                bad_val_r <= smart_pkg::VAL_FULL;
            end else begin
                bad_val_r <= bad_q[7:0];
            end
            if (life_q >= 32'(smart_pkg::VAL_FULL)) begin
                life_r <= smart_pkg::VAL_ZERO;
            end else begin
                life_r <= 8'(smart_pkg::VAL_FULL - life_q[7:0]);
            end
        end
    end

    // Error counters, cleared at every power-on reset
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unc_cnt_r <= 8'h00;
            phy_cnt_r <= 32'h0;
        end else begin
            if (i_uncorr_evt && unc_cnt_r != 8'hFF) begin
                unc_cnt_r <= unc_cnt_r + 8'h01;
            end
            if (i_phy_err_evt && phy_cnt_r != 32'hFFFF_FFFF) begin
                phy_cnt_r <= phy_cnt_r + 32'h1;
            end
        end
    end

    // --------
    // Sector byte generation
    // --------

    // Per-record value, worst and raw fields
    always_comb begin
        raw   = 48'h0;
        val   = smart_pkg::VAL_FULL;
        worst = smart_pkg::VAL_FULL;
        unique case (rec_r)
            4'h0: raw = {24'h0, unc_cnt_r, 16'h0};
            4'h1: raw = {32'h0, i_power_on_hours};
            4'h2: raw = {16'h0, i_power_cycles};
            4'h3: raw = {16'h0, phy_cnt_r};
            4'h4: begin
                val   = bad_val_r;
                worst = bad_val_r;
                raw   = {i_later_bad, 16'h0, i_early_bad};
            end
            4'h5: raw = {16'h0, i_avg_erase, i_max_erase};
            4'h6: raw = {16'h0, i_power_loss};
            4'h7: begin
                val   = 8'(smart_pkg::VAL_FULL - i_temp_cur);
                worst = 8'(smart_pkg::VAL_FULL - i_temp_high);
                raw   = {8'h0, i_temp_high, 8'h0, i_temp_low, 8'h0, i_temp_cur};
            end
            4'h8: raw = {16'h0, i_crc_errs};
            4'h9: raw = {40'h0, life_r};
            4'hA: begin
                val   = smart_pkg::VAL_ZERO;
                worst = smart_pkg::VAL_ZERO;
                raw   = {16'h0, i_host_write_gb};
            end
            default: raw = 48'h0;
        endcase
    end

    // Byte at the current sector position
    always_comb begin
        in_rec   = (pos_r >= smart_pkg::REC_BASE) && (rec_r <= smart_pkg::ATTR_LAST);
        byte_now = 8'h00;
        if (pos_r < smart_pkg::REC_BASE) begin
            byte_now = pos_r[0] ? smart_pkg::SECTOR_REV[15:8] : smart_pkg::SECTOR_REV[7:0];
        end else if (pos_r == smart_pkg::SECTOR_LAST) begin
            byte_now = 8'(~sum_r + 8'h01);
        end else if (in_rec && feat_r == smart_pkg::FEAT_READ_THR) begin
            if (off_r == smart_pkg::OFF_ID) begin
                byte_now = smart_pkg::ATTR_ID[rec_r];
            end else if (off_r == smart_pkg::OFF_THR_SECT) begin
                byte_now = smart_pkg::ATTR_THR[rec_r];
            end
        end else if (in_rec) begin
            unique case (off_r)
                smart_pkg::OFF_ID:    byte_now = smart_pkg::ATTR_ID[rec_r];
                smart_pkg::OFF_FLAG0: byte_now = smart_pkg::ATTR_FLAG[rec_r];
                smart_pkg::OFF_FLAG1: byte_now = 8'h00;
                smart_pkg::OFF_VALUE: byte_now = val;
                smart_pkg::OFF_WORST: byte_now = worst;
                smart_pkg::OFF_THR:   byte_now = smart_pkg::ATTR_THR[rec_r];
                default:              byte_now = raw[8*(off_r - smart_pkg::OFF_RAW) +: 8];
            endcase
        end
    end

    // Even bytes wait in a latch; odd bytes push a word and may stall
    assign fifo_valid = (state_r == ST_BUILD) && pos_r[0];
    assign advance    = (state_r == ST_BUILD) && (!pos_r[0] || fifo_ready);

    // Position, record and checksum counters
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pos_r     <= 9'h0;
            rec_r     <= 4'h0;
            off_r     <= 4'h0;
            sum_r     <= 8'h00;
            lo_byte_r <= 8'h00;
        end else if (state_r != ST_BUILD) begin
            pos_r <= 9'h0;
            rec_r <= 4'h0;
            off_r <= 4'h0;
            sum_r <= 8'h00;
        end else if (advance) begin
            pos_r <= pos_r + 9'h1;
            sum_r <= sum_r + byte_now;
            if (!pos_r[0]) begin
                lo_byte_r <= byte_now;
            end
            if (pos_r >= smart_pkg::REC_BASE && rec_r <= smart_pkg::ATTR_LAST) begin
                if (off_r == smart_pkg::REC_LAST_OFF) begin
                    off_r <= 4'h0;
                    rec_r <= rec_r + 4'h1;
                end else begin
                    off_r <= off_r + 4'h1;
                end
            end
        end
    end

    // --------
    // Command sequencing
    // --------
    assign dispatch = (state_r == ST_YIELD) &&
                      (!i_save_busy || yield_cnt_r >= YIELD_CYCLES - 29'h1);

    // Main state machine
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: if (accept) begin
                    state_r <= ST_YIELD;
                end
                ST_YIELD: if (abort_r) begin
                    state_r <= ST_DONE;
                end else if (dispatch) begin
                    state_r <= (feat_r == smart_pkg::FEAT_AUTOSAVE) ? ST_DONE : ST_BUILD;
                end
                ST_BUILD: if (advance && pos_r == smart_pkg::SECTOR_LAST) begin
                    state_r <= ST_DONE;
                end
                ST_DONE: state_r <= ST_IDLE;
            endcase
        end
    end

    // Command capture and abort decision
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            feat_r  <= 8'h00;
            cnt_r   <= 8'h00;
            abort_r <= 1'b0;
        end else if (accept) begin
            feat_r  <= i_feature;
            cnt_r   <= i_count;
            abort_r <= !sig_ok(i_cyl_lo, i_cyl_hi, i_command) ||
                       !feat_known(i_feature, i_count);
        end
    end

    // Bounded wait for a running save routine
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            yield_cnt_r <= 29'h0;
        end else if (state_r != ST_YIELD) begin
            yield_cnt_r <= 29'h0;
        end else if (i_save_busy) begin
            yield_cnt_r <= yield_cnt_r + 29'h1;
        end
    end

    // Completion status
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done       <= 1'b0;
            o_status     <= smart_pkg::STATUS_OK;
            o_error      <= smart_pkg::ERROR_NONE;
            o_drive_head <= smart_pkg::DRIVE_HEAD_OUT;
        end else begin
            o_done <= (state_r == ST_DONE);
            if (state_r == ST_DONE) begin
                o_status     <= abort_r ? smart_pkg::STATUS_ERR : smart_pkg::STATUS_OK;
                o_error      <= abort_r ? smart_pkg::ERROR_ABORT : smart_pkg::ERROR_NONE;
                o_drive_head <= smart_pkg::DRIVE_HEAD_OUT;
            end
        end
    end

    // --------
    // Autosave state and save requests
    // --------

    // Load persisted state after reset, then follow commands
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            autosave_r <= 1'b0;
            loaded_r   <= 1'b0;
            o_nv_wr    <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
            o_nv_wr  <= 1'b0;
            if (!loaded_r) begin
                autosave_r <= i_nv_autosave;
            end else if (dispatch && !abort_r && feat_r == smart_pkg::FEAT_AUTOSAVE) begin
                autosave_r <= (cnt_r == smart_pkg::CNT_AS_ON);
                o_nv_wr    <= 1'b1;
            end
        end
    end

    // Save request on own event when enabled, or on system events always
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_save_req <= 1'b0;
        end else begin
            o_save_req <= (i_save_event && autosave_r) || i_sys_save_event;
        end
    end

    // --------
    // Output word buffer
    // --------
    smart_word_fifo #(
        .WIDTH (smart_pkg::FIFO_WIDTH),
        .DEPTH (smart_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (fifo_valid),
        .o_in_ready  (fifo_ready),
        .i_in_data   ({byte_now, lo_byte_r}),
        .o_out_valid (o_data_valid),
        .i_out_ready (i_data_ready),
        .o_out_data  (o_data)
    );
endmodule
`default_nettype wire

/* File: rtl/smart_pkg.sv */
// Constants for the health-monitoring command unit
//
// Notes on behaviour
// - Each attribute record: id, two flags, value, worst, six raw bytes, threshold.
// - Life remaining = 100 - avg/max erase * 100; max 3000 multi-level, 20000 single-level.
// - Bad-block value = 100*(allowed-current)/allowed, clamped between 1 and 100.
// - Current bad-block term is the largest count over all planes.
// - Read-thresholds returns exactly one sector by PIO data-in.
// - Autosave-enable subcommand sets autosave state to enabled.
// - While autosave enabled, device may save attributes on its own event.
// - Autosave state kept in persistent storage across power cycles and resets.
// - Autosave subcommand with count zero disables autosave.
// - Autosave subcommand with count F1h enables autosave.
// - Other autosave count values get one fixed, documented behaviour.
// - Disabled autosave still allows saves at power-on, power-off, error recovery.
// - Command arriving during autosave routine starts processing within 2 s.
// - Read-attribute-data returns exactly one sector of attribute records.
// - Link error count covers only time since power-on; cleared at power-off.
// - Uncorrectable-error attribute stays within 0 to 255.
package smart_pkg;

    // --------
    // Clock and timing
    // --------
    localparam longint CLK_HZ         = 250_000_000;
    localparam longint YIELD_TIME_S   = 2;
    localparam longint YIELD_CYCLES   = YIELD_TIME_S * CLK_HZ;
    localparam int     YIELD_W        = 29;

    // --------
    // Taskfile codes
    // --------
    localparam logic [7:0] CMD_SMART      = 8'hB0;
    localparam logic [7:0] SIG_CYL_LO     = 8'h4F;
    localparam logic [7:0] SIG_CYL_HI     = 8'hC2;
    localparam logic [7:0] FEAT_READ_DATA = 8'hD0;
    localparam logic [7:0] FEAT_READ_THR  = 8'hD1;
    localparam logic [7:0] FEAT_AUTOSAVE  = 8'hD2;
    localparam logic [7:0] CNT_AS_OFF     = 8'h00;
    localparam logic [7:0] CNT_AS_ON      = 8'hF1;
    localparam logic [7:0] STATUS_OK      = 8'h50;
    localparam logic [7:0] STATUS_ERR     = 8'h51;
    localparam logic [7:0] ERROR_NONE     = 8'h00;
    localparam logic [7:0] ERROR_ABORT    = 8'h04;
    localparam logic [7:0] DRIVE_HEAD_OUT = 8'hE0;

    // --------
    // Sector layout
    // --------
    localparam logic [8:0]  SECTOR_LAST   = 9'h1FF;
    localparam logic [8:0]  REC_BASE      = 9'h002;
    localparam logic [3:0]  REC_LAST_OFF  = 4'hB;
    localparam logic [3:0]  OFF_ID        = 4'h0;
    localparam logic [3:0]  OFF_FLAG0     = 4'h1;
    localparam logic [3:0]  OFF_FLAG1     = 4'h2;
    localparam logic [3:0]  OFF_VALUE     = 4'h3;
    localparam logic [3:0]  OFF_WORST     = 4'h4;
    localparam logic [3:0]  OFF_RAW       = 4'h5;
    localparam logic [3:0]  OFF_THR       = 4'hB;
    localparam logic [3:0]  OFF_THR_SECT  = 4'h1;
    localparam logic [15:0] SECTOR_REV    = 16'h0010;
    localparam int          NUM_ATTR      = 11;
    localparam logic [3:0]  ATTR_LAST     = 4'hA;

    localparam logic [7:0] ATTR_ID   [0:10] = '{8'h01, 8'h09, 8'h0C, 8'hA8, 8'hAA, 8'hAD,
                                               8'hC0, 8'hC2, 8'hDA, 8'hE7, 8'hF1};
    localparam logic [7:0] ATTR_FLAG [0:10] = '{8'h0B, 8'h12, 8'h12, 8'h12, 8'h03, 8'h12,
                                               8'h12, 8'h23, 8'h0B, 8'h13, 8'h32};
    localparam logic [7:0] ATTR_THR  [0:10] = '{8'h32, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h00,
                                               8'h00, 8'h1E, 8'h32, 8'h00, 8'h00};

    // --------
    // Attribute arithmetic
    // --------
    localparam logic [7:0]  VAL_FULL       = 8'h64;
    localparam logic [7:0]  VAL_ZERO       = 8'h00;
    localparam logic [7:0]  BAD_MIN        = 8'h01;
    localparam logic [31:0] PCT_SCALE      = 32'h0000_0064;
    localparam logic [15:0] ERASE_MAX_MLC  = 16'h0BB8;
    localparam logic [15:0] ERASE_MAX_SLC  = 16'h4E20;
    localparam int          NPLANE         = 4;

    // --------
    // Data path
    // --------
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 8;

endpackage

/* File: rtl/smart_word_fifo.sv */
// Word FIFO between the sector builder and the PIO data-in port
`timescale 1ns/1ps
`default_nettype none
module smart_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             push;
    logic             pop;

    // Full and empty from pointer wrap bits
    assign o_out_valid = (wr_ptr_r != rd_ptr_r);
    assign o_in_ready  = !((wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                           (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_r[rd_ptr_r[AW-1:0]];

    // Storage write
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
        end
    end

    // Pointers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/smart_attribute_command_unit_bench.sv */
// Self-checking bench for the health-monitoring command unit
`timescale 1ns/1ps
`default_nettype none
module smart_attribute_command_unit_bench;
    logic         clk = 0, rst_n = 0, valid = 0, slow = 0, slc = 0, nv = 1, exp_as = 1;
    logic [7:0]   feat = 0, cnt = 0, cmd = 0, cyl = 8'h4F, status, error;
    logic [15:0]  allowed = 0, avg = 0, word;
    logic [63:0]  planes = 0;
    logic [383:0] r = 0;
    logic         cready, done, dv, ready, nv_wr, nv_val, as_en;
    int           num_errors = 0, checked = 0, seed = 76;
    logic [23:0]  tc [6] = '{24'hD2F1B0, 24'hD200B0, 24'hD25AB0, 24'hD2F1B0, 24'hD2F1EC,
                             24'hD200EC};
    smart_attribute_command_unit #(.YIELD_CYCLES(29'h14)) dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_cmd_valid(valid), .o_cmd_ready(cready),
        .i_feature(feat), .i_count(cnt), .i_cyl_lo(cyl), .i_cyl_hi(8'hC2),
        .i_command(cmd), .o_done(done), .o_status(status), .o_error(error),
        .o_drive_head(), .o_data_valid(dv), .i_data_ready(ready), .o_data(word),
        .i_uncorr_evt(r[0]), .i_phy_err_evt(r[1]), .i_power_on_hours(r[31:16]),
        .i_power_cycles(r[63:32]), .i_early_bad(r[79:64]), .i_later_bad(r[95:80]),
        .i_plane_bad(planes), .i_bad_allowed(allowed), .i_max_erase(r[111:96]),
        .i_avg_erase(avg), .i_slc_mode(slc), .i_power_loss(r[143:112]),
        .i_temp_cur(r[151:144]), .i_temp_low(r[159:152]), .i_temp_high(r[167:160]),
        .i_crc_errs(r[199:168]), .i_host_write_gb(r[231:200]), .i_nv_autosave(nv),
        .o_nv_wr(nv_wr), .o_nv_autosave(nv_val), .o_autosave_en(as_en),
        .i_save_event(r[2]), .i_sys_save_event(r[3]), .i_save_busy(r[5]),
        .o_save_req(), .o_save_yield());
    smart_host_model u_host (.i_clk_sys(clk), .i_stall(r[4] & slow), .i_valid(dv),
        .i_word(word), .o_ready(ready));
    // Clock, random inputs and the persistent store
    initial forever #2 clk = ~clk;
    always @(negedge clk) for (int k = 0; k < 12; k++) r[32*k+:32] = $random(seed);
    always @(posedge clk) if (nv_wr) nv <= nv_val;
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic wait_hi(ref logic s);
        for (int w = 0; s !== 1'b1; w++) begin
            if (w == 3000) begin num_errors++; final_report; end
            @(negedge clk);
        end
    endtask
    task automatic issue(logic [7:0] f, c, k);
        @(negedge clk); feat = f; cnt = c; cmd = k; valid = 1;
        wait_hi(cready);
        @(negedge clk); valid = 0;
        wait_hi(done);
    endtask
    function automatic logic [7:0] bad_val(logic [63:0] p, logic [15:0] a);
        int b = 0, v;
        for (int i = 0; i < 4; i++) if (p[16*i+:16] > b) b = p[16*i+:16];
        v = (a == 0 || b >= a) ? 1 : 100 * (a - b) / a;
        return 8'(v < 1 ? 1 : v);
    endfunction
    function automatic logic [7:0] life(logic [15:0] a, logic s);
        int v = 100 - a * 100 / (s ? 20000 : 3000);
        return 8'(v < 0 ? 0 : v);
    endfunction
    task automatic sector(logic thr);
        logic [7:0] s = 0;
        repeat (64) if (dv) @(negedge clk);
        chk("words", 256, 16'(u_host.n));
        chk("status", 16'h0050, status);
        for (int i = 0; i < 512; i++) s += u_host.sect[i];
        chk("sum", 0, s);
        for (int k = 0; k < 11; k++) begin
            chk("id", smart_pkg::ATTR_ID[k], u_host.sect[2+12*k]);
            chk("thr", smart_pkg::ATTR_THR[k], u_host.sect[(thr ? 3 : 13)+12*k]);
        end
        if (!thr) chk("bad", bad_val(planes, allowed), u_host.sect[53]);
        if (!thr) chk("life", life(avg, slc), u_host.sect[115]);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        @(negedge clk); chk("load", 1, as_en);
        foreach (tc[i]) begin
            issue(tc[i][23:16], tc[i][15:8], tc[i][7:0]);
            if (cmd == 8'hB0 && (cnt == 8'h00 || cnt == 8'hF1)) begin
                exp_as = (cnt == 8'hF1);
                chk("status", 16'h0050, status);
            end else chk("status", 16'h0051, status);
            chk("autosave", exp_as, as_en);
        end
        rst_n = 0;
        @(negedge clk); rst_n = 1;
        @(negedge clk); chk("kept", exp_as, as_en);
        cyl = 8'h4E; issue(8'hD0, 8'h01, 8'hB0); cyl = 8'h4F;
        chk("bad sig", 16'h0051, status);
        for (int j = 0; j < 2; j++) begin
            slow = j; slc = j; avg = 16'($random(seed)) & 16'h0FFF;
            planes = {$random(seed), $random(seed)} & 64'h01FF01FF01FF01FF;
            allowed = j ? 16'h0000 : 16'h0180;
            u_host.n = 0; issue(8'hD0, 8'h01, 8'hB0); sector(0);
            u_host.n = 0; issue(8'hD1, 8'h01, 8'hB0); sector(1);
        end
        final_report;
    end
endmodule
bind smart_attribute_command_unit smart_props #(.YIELD_CYCLES(YIELD_CYCLES)) u_props (.*);
`default_nettype wire

/* File: tb/smart_host_model.sv */
// Host-side model that collects PIO data-in words
`timescale 1ns/1ps
`default_nettype none
module smart_host_model (
    // Data-in handshake
    input  wire logic        i_clk_sys,
    input  wire logic        i_stall,
    input  wire logic        i_valid,
    input  wire logic [15:0] i_word,
    output logic             o_ready
);
    logic [7:0] sect [0:511];
    int         n = 0;
    // Ready follows the stall pattern set off the sampling edge
    assign o_ready = !i_stall;
    // Store each taken word, low byte first
    always @(posedge i_clk_sys) begin
        if (i_valid && o_ready) begin
            sect[2*n]   <= i_word[7:0];
            sect[2*n+1] <= i_word[15:8];
            n           <= n + 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/smart_props.sv */
// Port checks for the health-monitoring command unit
`timescale 1ns/1ps
`default_nettype none
module smart_props #(
    parameter logic [28:0] YIELD_CYCLES = 29'h14
) (
    // Watched ports, grouped by width
    input wire logic       i_clk_sys, i_rst_n, i_cmd_valid, o_cmd_ready, o_done, o_save_yield,
    input wire logic       i_save_event, i_sys_save_event, o_save_req, o_autosave_en,
    input wire logic [7:0] i_feature, i_count, i_cyl_lo, i_cyl_hi, i_command,
    input wire logic [7:0] o_status, o_error, o_drive_head
);
    // Accepted autosave command with a good signature
    wire tk = i_cmd_valid && o_cmd_ready;
    wire as = tk && i_feature == 8'hD2 && i_cyl_lo == 8'h4F && i_cyl_hi == 8'hC2
              && i_command == 8'hB0;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    head_fixed_a: assert property (o_drive_head == 8'hE0)
        else $error("drive head not E0");
    status_pair_a: assert property (o_done |-> o_status == 8'h50 && o_error == 8'h00
        || o_status == 8'h51 && o_error == 8'h04) else $error("bad status pair");
    opcode_abort_a: assert property (tk && i_command != 8'hB0 |-> ##[1:30] o_done
        && o_status == 8'h51) else $error("wrong opcode not aborted");
    as_on_a: assert property (as && i_count == 8'hF1 |-> ##[1:30] o_autosave_en)
        else $error("autosave not enabled");
    as_off_a: assert property (as && i_count == 8'h00 |-> ##[1:30] !o_autosave_en)
        else $error("autosave not disabled");
    as_odd_a: assert property (as && i_count != 8'h00 && i_count != 8'hF1
        |=> $stable(o_autosave_en) [*4]) else $error("odd count changed autosave");
    yield_bound_a: assert property (as |-> ##[1:30] o_done)
        else $error("command not served in time");
    sys_save_a: assert property (i_sys_save_event |=> o_save_req)
        else $error("system save not requested");
    save_gate_a: assert property (o_save_req |-> $past(i_sys_save_event
        || i_save_event && o_autosave_en)) else $error("save request without cause");
    yield_flag_a: assert property (tk |=> o_save_yield)
        else $error("command not held for save");
    cover property (as && i_count == 8'hF1);
    cover property (tk && i_feature == 8'hD0);
    cover property (o_save_req && !o_autosave_en);
endmodule
`default_nettype wire
